// ---- design/effecter_readback_pkg.sv ----
// constants, types and register map of the effecter state readback block
package effecter_readback_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] QUERY_OFF = 8'h04;
   localparam logic [2:0] CFG_PAGE = 3'h1; // 0x20..0x3c, one per member
   localparam logic [2:0] RESP_PAGE = 3'h2; // 0x40..0x5c, one per member
   // field positions
   localparam int CTRL_COUNT_LSB = 16;
   localparam int CFG_TARGET_LSB = 8;
   localparam int CFG_SET_BIT = 16;
   localparam int QUERY_COUNT_LSB = 8;
   // sizes and reset values
   localparam int MEMBERS = 8;
   localparam logic [3:0] MAX_COUNT = 4'h8;
   localparam logic [3:0] MIN_COUNT = 4'h1;
   localparam logic [15:0] HANDLE_RESET = 16'h0001;
   localparam logic [3:0] COUNT_RESET = 4'h8;
   localparam logic [7:0] STATE_RESET = 8'h01;
   localparam logic [7:0] UNKNOWN_STATE = 8'h00;
   localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
   localparam logic [15:0] HANDLE_RSVD_HI = 16'hffff;
   // result codes
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] BAD_HANDLE_ERROR = 8'h80;
   // settle time of an effecter after a set request
   localparam int SETTLE_TIME_NS = 32;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_CYCLES =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SETTLE_LOAD = 3'(SETTLE_CYCLES - 1);

   // operational condition codes, in wire order
   typedef enum logic [7:0] {
      ACTIVE_CHANGE_QUEUED,
      ACTIVE_SETTLED,
      DISABLED,
      UNAVAILABLE,
      FAILED,
      UNDER_SELF_CHECK
   } condition_type;

   // one member's three response bytes
   typedef struct packed {
      condition_type actuator_condition;
      logic [7:0] target_in_progress;
      logic [7:0] applied_output_state;
   } state_field_type;

   // classic wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;
endpackage

// ---- design/effecter_state_readback.sv ----
// state effecter readback: member models, query response and bus slave
//
// Behaviour
// - each member reports an 8-bit condition, one of six codes
// - with an update queued, pending field shows the requested target
// - with nothing queued, pending field shows the current state
// - pending field is unknown code unless condition is one of two enabled
// - pending field uses the member's own state set codes
// - separate 8-bit field reports the state actually applied
// - applied field is unknown code unless condition is one of two enabled
// - applied field uses the member's own state set codes
// - one handle covers one to eight members; count then per-member fields
// - unknown or reserved handle answers with result code 0x80
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module effecter_state_readback (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire effecter_readback_pkg::wb_req_type wb_req_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o
);
   import effecter_readback_pkg::*;

   logic ack_q;
   logic [31:0] rdat_q;
   logic [15:0] handle_q;
   logic [3:0] count_q;
   logic [7:0] result_q;
   logic [3:0] resp_count_q;
   state_field_type resp_q [MEMBERS];
   state_field_type live_w [MEMBERS];
   logic [31:0] cfg_view_w [MEMBERS];
   logic pend_w [MEMBERS];
   logic accept_w [MEMBERS];
   logic enabled_w [MEMBERS];

   // bus decode; the write acts on the edge that raises ack
   wire req_w = wb_req_i.cyc & wb_req_i.stb;
   wire take_w = req_w & ~ack_q;
   wire wr_w = take_w & wb_req_i.we;
   wire [2:0] idx_w = wb_req_i.adr[4:2];
   wire ctrl_hit_w = wb_req_i.adr == CTRL_OFF;
   wire query_hit_w = wb_req_i.adr == QUERY_OFF;
   wire cfg_hit_w = wb_req_i.adr[7:5] == CFG_PAGE && wb_req_i.adr[1:0] == 2'h0;
   wire resp_hit_w =
      wb_req_i.adr[7:5] == RESP_PAGE && wb_req_i.adr[1:0] == 2'h0;

   // count field clamped into the legal member range
   wire [3:0] count_in_w = wb_req_i.dat[CTRL_COUNT_LSB +: 4];
   wire [3:0] count_clamp_w = (count_in_w < MIN_COUNT) ? MIN_COUNT :
      (count_in_w > MAX_COUNT) ? MAX_COUNT : count_in_w;

   // query handle check; reserved handles never match
   wire [15:0] qhandle_w = wb_req_i.dat[15:0];
   wire handle_ok_w = qhandle_w == handle_q &&
      qhandle_w != HANDLE_RSVD_LO && qhandle_w != HANDLE_RSVD_HI;
   wire query_w = wr_w & query_hit_w & (&wb_req_i.sel[1:0]);

   // read data select; unmapped addresses read as zero
   wire [31:0] rd_w =
      ctrl_hit_w ? {12'h000, count_q, handle_q} :
      query_hit_w ? {20'h00000, resp_count_q, result_q} :
      cfg_hit_w ? cfg_view_w[idx_w] :
      resp_hit_w ? {8'h00, resp_q[idx_w]} : 32'h0000_0000;

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // single-wait-state slave: ack one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= take_w;
         rdat_q <= take_w ? rd_w : rdat_q;
      end
   end

   // handle and member count, byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         handle_q <= HANDLE_RESET;
         count_q <= COUNT_RESET;
      end else if (wr_w && ctrl_hit_w) begin
         if (wb_req_i.sel[0]) handle_q[7:0] <= wb_req_i.dat[7:0];
         if (wb_req_i.sel[1]) handle_q[15:8] <= wb_req_i.dat[15:8];
         if (wb_req_i.sel[2]) count_q <= count_clamp_w;
      end
   end

   // query result; bad handle reports zero members
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_q <= RESULT_OK;
         resp_count_q <= 4'h0;
      end else if (query_w) begin
         result_q <= handle_ok_w ? RESULT_OK : BAD_HANDLE_ERROR;
         resp_count_q <= handle_ok_w ? count_q : 4'h0;
      end
   end

   // one effecter model and snapshot per member
   for (genvar i = 0; i < MEMBERS; i++) begin : g_member
      logic [7:0] cond_cfg_q;
      logic [7:0] target_q;
      logic [7:0] applied_q;
      logic pend_q;
      logic [2:0] cnt_q;
      wire sel_w = wr_w & cfg_hit_w & (idx_w == 3'(i));
      wire [7:0] code_w = wb_req_i.dat[7:0];
      // both enabled codes store as enabled; illegal codes fall to disabled
      wire [7:0] cond_in_w = (code_w <= 8'(ACTIVE_SETTLED)) ?
         8'(ACTIVE_SETTLED) :
         (code_w <= 8'(UNDER_SELF_CHECK)) ? code_w : 8'(DISABLED);
      wire cond_wr_w = sel_w & wb_req_i.sel[0];
      wire in_range_w = 4'(i) < count_q;

      assign enabled_w[i] = cond_cfg_q == 8'(ACTIVE_SETTLED);
      // sets are taken only by an enabled member
      assign accept_w[i] = sel_w & wb_req_i.sel[2] &
         wb_req_i.dat[CFG_SET_BIT] & enabled_w[i];
      assign pend_w[i] = pend_q;
      assign cfg_view_w[i] = {15'h0000, pend_q, target_q, cond_cfg_q};

      // reported condition follows the queue while enabled
      assign live_w[i].actuator_condition = !enabled_w[i] ?
         condition_type'(cond_cfg_q) :
         pend_q ? ACTIVE_CHANGE_QUEUED : ACTIVE_SETTLED;
      // opaque 8-bit codes of this member's own state set
      assign live_w[i].target_in_progress = !enabled_w[i] ? UNKNOWN_STATE :
         pend_q ? target_q : applied_q;
      assign live_w[i].applied_output_state = enabled_w[i] ?
         applied_q : UNKNOWN_STATE;

      // a second set while queued retargets without restarting the wait
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cond_cfg_q <= 8'(ACTIVE_SETTLED);
            target_q <= STATE_RESET;
            applied_q <= STATE_RESET;
            pend_q <= 1'b0;
            cnt_q <= 3'h0;
         end else begin
            if (cond_wr_w) cond_cfg_q <= cond_in_w;
            if (accept_w[i]) target_q <= wb_req_i.dat[CFG_TARGET_LSB +: 8];
            if (cond_wr_w && cond_in_w != 8'(ACTIVE_SETTLED)) begin
               pend_q <= 1'b0; // leaving enabled drops the queued change
            end else if (accept_w[i] && !pend_q) begin
               pend_q <= 1'b1;
               cnt_q <= SETTLE_LOAD;
            end else if (pend_q) begin
               if (cnt_q == 3'h0) begin
                  pend_q <= 1'b0;
                  applied_q <= target_q;
               end else begin
                  cnt_q <= cnt_q - 3'h1;
               end
            end
         end
      end

      // snapshot taken at the query; members beyond the count read zero
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            resp_q[i] <= '0;
         end else if (query_w) begin
            resp_q[i] <= (handle_ok_w && in_range_w) ? live_w[i] : '0;
         end
      end
   end

   // checks on member 0 and on the query path
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_cond_legal;
      live_w[0].actuator_condition <= UNDER_SELF_CHECK;
   endproperty
   a_cond_legal: assert property (p_cond_legal)
      else $error("condition code out of range");

   property p_pending_target;
      enabled_w[0] && pend_w[0] |->
         live_w[0].actuator_condition == ACTIVE_CHANGE_QUEUED &&
         live_w[0].target_in_progress == g_member[0].target_q;
   endproperty
   a_pending_target: assert property (p_pending_target)
      else $error("queued member does not show its target");

   property p_settled_current;
      enabled_w[0] && !pend_w[0] |->
         live_w[0].target_in_progress == live_w[0].applied_output_state;
   endproperty
   a_settled_current: assert property (p_settled_current)
      else $error("settled member pending field differs from applied");

   property p_unknown_fields;
      live_w[0].actuator_condition > ACTIVE_SETTLED |->
         live_w[0].target_in_progress == UNKNOWN_STATE &&
         live_w[0].applied_output_state == UNKNOWN_STATE;
   endproperty
   a_unknown_fields: assert property (p_unknown_fields)
      else $error("inactive member shows a state value");

   property p_applied_follows;
      enabled_w[0] && pend_w[0] && g_member[0].cnt_q == 3'h0 |=>
         live_w[0].applied_output_state == $past(g_member[0].target_q);
   endproperty
   a_applied_follows: assert property (p_applied_follows)
      else $error("applied state did not take the target");

   property p_settle_sequence;
      accept_w[0] && !pend_w[0] ##1 enabled_w[0] [*4] |=>
         $past(pend_w[0], 3) && !pend_w[0];
   endproperty
   a_settle_sequence: assert property (p_settle_sequence)
      else $error("queued change did not settle on time");

   property p_count_range;
      query_w |=> (result_q == RESULT_OK) ?
         (resp_count_q >= MIN_COUNT && resp_count_q <= MAX_COUNT) :
         resp_count_q == 4'h0;
   endproperty
   a_count_range: assert property (p_count_range)
      else $error("reported member count out of range");

   property p_bad_handle;
      query_w && (qhandle_w == HANDLE_RSVD_LO ||
         qhandle_w == HANDLE_RSVD_HI || qhandle_w != handle_q) |=>
         result_q == BAD_HANDLE_ERROR ##1 result_q == BAD_HANDLE_ERROR;
   endproperty
   a_bad_handle: assert property (p_bad_handle)
      else $error("bad handle not refused with 0x80");

   c_settle: cover property (accept_w[0] ##[1:8] !pend_w[0]);
   c_good_query: cover property (query_w && handle_ok_w);
   c_bad_query: cover property (query_w && !handle_ok_w);
   c_disabled: cover property (live_w[0].actuator_condition == DISABLED);
endmodule
`default_nettype wire

// ---- testbench/test_effecter_state_readback.sv ----
// self-checking bench for the effecter state readback block
`timescale 1ns/1ps
`default_nettype none
module test_effecter_state_readback;
   import effecter_readback_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_ack_o;
   logic [31:0] wb_dat_o;
   wb_req_type wb_req;
   logic [39:0] notes[$];
   int n_mismatch = 0;
   int checks = 0;
   logic [31:0] lfsr_q = 32'hce25d672;
   logic [7:0] tgt;
   logic [7:0] codes[6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
   logic [7:0] conds[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h02};
   logic [15:0] bad[3] = '{16'h0000, 16'hffff, 16'h1234};

   always #4 clk_i = ~clk_i;

   effecter_state_readback dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_req_i(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
   wb_requester req (.clk_i(clk_i), .ack_i(wb_ack_o), .req_o(wb_req));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [7:0] adr, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected data at %h: expected %h seen %h", adr, exp,
                  seen);
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      req.access(1'b1, adr, dat, 4'hf);
   endtask

   // the note is queued before the read is issued
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      notes.push_back({adr, exp});
      req.access(1'b0, adr, 32'h0, 4'hf);
   endtask

   task automatic query(input logic [15:0] h);
      wr(QUERY_OFF, {16'h0, h});
   endtask

   // expected response word of member i, fields masked when not enabled
   task automatic rd_resp(input int i, input logic [7:0] c,
                          input logic [7:0] p, input logic [7:0] a);
      rd(8'h40 + 8'(4 * i),
         req.fields_valid(c) ? {8'h0, c, p, a} : {8'h0, c, 16'h0});
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // read results are matched in order against the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && notes.size() > 0) begin
         logic [39:0] n;
         n = notes.pop_front();
         check(n[39:32], wb_dat_o, n[31:0]);
      end
   end

   // watchdog well beyond the fewer than two hundred cycles of the sequence
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(CTRL_OFF, 32'h0008_0001);
      rd(8'h20, 32'h0000_0101);
      query(HANDLE_RESET);
      rd(QUERY_OFF, 32'h0000_0800);
      rd_resp(0, 8'h01, STATE_RESET, STATE_RESET);
      foreach (bad[k]) begin
         query(bad[k]);
         rd(QUERY_OFF, {24'h0, BAD_HANDLE_ERROR});
         rd(8'h40, 32'h0);
      end
      // set on member 0, where the checks sit: snapshot three cycles in
      lfsr_q = lfsr(lfsr_q);
      tgt = lfsr_q[7:0];
      wr(8'h20, {15'h0, 1'b1, tgt, 8'h01});
      query(HANDLE_RESET);
      rd_resp(0, 8'h00, tgt, STATE_RESET);
      query(HANDLE_RESET);
      rd_resp(0, 8'h01, tgt, tgt);
      rd(8'h20, {16'h0, tgt, 8'h01});
      // condition codes 00 and 02 to 06 written to member 2, 06 being illegal
      foreach (codes[k]) begin
         wr(8'h28, {24'h0, codes[k]});
         rd(8'h28, {16'h0, STATE_RESET, conds[k]});
         query(HANDLE_RESET);
         rd_resp(2, conds[k], STATE_RESET, STATE_RESET);
      end
      // member count clamping and a moved handle
      wr(CTRL_OFF, 32'h0000_0001);
      rd(CTRL_OFF, 32'h0001_0001);
      wr(CTRL_OFF, 32'h0009_0001);
      rd(CTRL_OFF, 32'h0008_0001);
      wr(CTRL_OFF, 32'h0003_0042);
      query(HANDLE_RESET);
      rd(QUERY_OFF, {24'h0, BAD_HANDLE_ERROR});
      query(16'h0042);
      rd(QUERY_OFF, 32'h0000_0300);
      rd_resp(0, 8'h01, tgt, tgt);
      rd(8'h4c, 32'h0);
      rd(8'h10, 32'h0);
      repeat (4) @(posedge clk_i);
      end_sim();
   end
endmodule
`default_nettype wire

// ---- testbench/wb_requester.sv ----
// management requester model: classic wishbone master for the readback block
`timescale 1ns/1ps
`default_nettype none
module wb_requester
   import effecter_readback_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   output var wb_req_type req_o
);
   initial req_o = '0;

   // one classic cycle; request held until ack is sampled, then released
   task automatic access(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat, input logic [3:0] sel);
      @(posedge clk_i);
      req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
      // no limit here: only the bench watchdog may end a hung wait
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      req_o <= '0; // low for at least the next cycle
   endtask

   // state fields carry meaning only for the two enabled conditions
   function automatic logic fields_valid(input logic [7:0] cond);
      return cond <= 8'h01;
   endfunction
endmodule
`default_nettype wire
